// ===== include/pxwa_map.svh
// Constants of the pixel-to-word addressing block
`ifndef PXWA_MAP_SVH
`define PXWA_MAP_SVH
`define PXWA_WORD_W      32
`define PXWA_ADDR_W      32
`define PXWA_CNT_W       16
`define PXWA_POS_W       5
`define PXWA_BUF_DEPTH   32
`define PXWA_SKID_DEPTH  2
`define PXWA_FMT_4BPP    3'h0
`define PXWA_FMT_8BPP    3'h1
`define PXWA_FMT_16BPP   3'h2
`define PXWA_FMT_24PK    3'h3
`define PXWA_FMT_24UP    3'h4
`define PXWA_NIB_EVEN_LSB 5'h04
`define PXWA_NIB_ODD_LSB  5'h00
`define PXWA_BYTES_24    3'h3
`endif

// ===== include/pxwa_pkg.sv
// Types of the pixel-to-word addressing block
package pxwa_pkg;
   typedef enum logic [3:0]
   {
      PXWA_IDLE  = 4'h1,
      PXWA_READ  = 4'h2,
      PXWA_WRITE = 4'h4,
      PXWA_DONE  = 4'h8
   } pxwa_state_t;

   // One side of a transfer: start address, word count and pixel bounds
   typedef struct packed
   {
      logic [31:0] base_addr;
      logic [15:0] word_count;
      logic [4:0]  start_bit_position;
      logic [4:0]  end_bit_position;
   } pxwa_side_t;

   // Memory bus request
   typedef struct packed
   {
      logic        rd;
      logic        wr;
      logic [31:0] addr;
      logic [31:0] wdata;
      logic [3:0]  be;
   } pxwa_mreq_t;
endpackage

// ===== rtl/pxwa_skid.sv
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ns
`default_nettype none
module pxwa_skid #(
   parameter int W = 32
) (
   input  wire logic         clk,       // Clock
   input  wire logic         rst,       // Sync reset, high
   input  wire logic         in_valid,  // Upstream word valid
   output logic              in_ready,  // Space available
   input  wire logic [W-1:0] in_data,   // Upstream word
   output logic              out_valid, // Word available
   input  wire logic         out_ready, // Downstream accepts
   output logic [W-1:0]      out_data   // Oldest word
);
   typedef struct packed
   {
      logic [1:0][W-1:0] mem;
      logic              rp;
      logic              wp;
      logic [1:0]        cnt;
   } pxwa_skst_t;

   pxwa_skst_t s_q;
   pxwa_skst_t s_d;
   logic       push;
   logic       pop;

   // Handshakes
   assign in_ready  = (s_q.cnt != 2'h2);
   assign out_valid = (s_q.cnt != 2'h0);
   assign out_data  = s_q.mem[s_q.rp];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   // Next state
   always_comb
   begin
      s_d = s_q;
      if (push)
      begin
         s_d.mem[s_q.wp] = in_data;
         s_d.wp          = ~s_q.wp;
      end
      if (pop)
         s_d.rp = ~s_q.rp;
      s_d.cnt = 2'(s_q.cnt + {1'b0, push} - {1'b0, pop});
   end

   // State register
   always_ff @(posedge clk)
   begin
      if (rst)
         s_q <= '0;
      else
         s_q <= s_d;
   end
endmodule
`default_nettype wire

// ===== rtl/pxwa_top.sv
// Pixel-to-word addressing and block copy engine
`timescale 1ns/1ns
`default_nettype none
`include "pxwa_map.svh"
module pxwa_top #(
   parameter int DEPTH = `PXWA_BUF_DEPTH
) (
   input  wire logic               SYS_CLK,     // 100 MHz clock
   input  wire logic               SYS_RST,     // Sync reset, high
   input  wire logic               START,       // Begin transfer pulse
   input  wire logic [2:0]         PIXEL_FMT,   // Pixel format code
   input  wire pxwa_pkg::pxwa_side_t SRC_SIDE,  // Source settings
   input  wire pxwa_pkg::pxwa_side_t DST_SIDE,  // Destination settings
   output logic                    BUSY,        // Transfer running
   output logic                    DONE,        // Transfer finished pulse
   output logic [31:0]             FIRST_MASK,  // Destination first-word mask
   output logic [31:0]             LAST_MASK,   // Destination last-word mask
   output pxwa_pkg::pxwa_mreq_t    MEM_REQ,     // Memory request
   input  wire logic               MEM_GNT,     // Request accepted
   input  wire logic               MEM_RVALID,  // Read data valid
   input  wire logic [31:0]        MEM_RDATA    // Read data
);
   localparam int PW = $clog2(DEPTH);

   typedef struct packed
   {
      pxwa_pkg::pxwa_state_t st;
      logic [31:0]           raddr;
      logic [31:0]           waddr;
      logic [15:0]           rleft;
      logic [15:0]           wleft;
      logic [15:0]           wpos;
      logic [15:0]           wlast;
      logic [PW:0]           inflight;
      logic [31:0]           fmask;
      logic [31:0]           lmask;
      logic                  done;
      logic                  rdwait;
   } pxwa_topst_t;

   pxwa_topst_t s_q;
   pxwa_topst_t s_d;
   logic [DEPTH-1:0][31:0] buf_q;
   logic [PW-1:0]          bwp_q;
   logic [PW-1:0]          brp_q;
   logic [PW:0]            bcnt_q;
   logic                   b_push;
   logic                   b_pop;
   logic                   sk_in_ready;
   logic                   sk_out_valid;
   logic [31:0]            sk_out_data;
   logic                   wr_fire;

   // Width of one pixel in bits for the format
   function automatic logic [5:0] pix_bits(input logic [2:0] f);
      unique case (f)
         `PXWA_FMT_4BPP:  pix_bits = 6'h04;
         `PXWA_FMT_8BPP:  pix_bits = 6'h08;
         `PXWA_FMT_16BPP: pix_bits = 6'h10;
         `PXWA_FMT_24PK:  pix_bits = 6'h18;
         default:         pix_bits = 6'h20;
      endcase
   endfunction

   // Bit lanes covered from a pixel's lowest bit to the word top, or to bit 23 in unpacked 24 bpp.
   // In 4 bpp the even pixel sits in the upper nibble, so a start
   // at bit 4 also covers the odd pixel's lower nibble.
   function automatic logic [31:0] head_mask(input logic [2:0] f,
                                             input logic [4:0] p);
      logic [4:0] lo;
      lo = p;
      if (f == `PXWA_FMT_4BPP && p[2:0] == 3'(`PXWA_NIB_EVEN_LSB))
         lo = {p[4:3], 3'h0};
      head_mask = 32'hffffffff << lo;
      if (f == `PXWA_FMT_24UP)
         head_mask = head_mask & 32'h00ffffff;
   endfunction

   // Bit lanes from word bottom through the last pixel
   function automatic logic [31:0] tail_mask(input logic [2:0] f,
                                             input logic [4:0] p);
      logic [5:0] top;
      logic [5:0] t;
      top = 6'(p) + pix_bits(f);
      if (f == `PXWA_FMT_4BPP)
         top = 6'({p[4:3], 3'h0} + 6'h08);
      if (f == `PXWA_FMT_24PK && top > 6'h20)
         top = 6'(top - 6'h20);
      if (f == `PXWA_FMT_24UP)
         top = 6'h18;
      t = 6'h20 - top;
      tail_mask = 32'hffffffff >> t;
   endfunction

   // Receiver stage: no word lost when memory stalls writes
   pxwa_skid #(
      .W (32)
   ) u_skid (
      .clk       (SYS_CLK),
      .rst       (SYS_RST),
      .in_valid  (bcnt_q != '0),
      .in_ready  (sk_in_ready),
      .in_data   (buf_q[brp_q]),
      .out_valid (sk_out_valid),
      .out_ready (wr_fire),
      .out_data  (sk_out_data)
   );

   assign b_push = MEM_RVALID;
   assign b_pop  = (bcnt_q != '0) && sk_in_ready;

   // Copy buffer groups reads ahead of writes
   always_ff @(posedge SYS_CLK)
   begin
      if (SYS_RST)
      begin
         bwp_q  <= '0;
         brp_q  <= '0;
         bcnt_q <= '0;
      end
      else
      begin
         if (b_push)
            bwp_q <= PW'(bwp_q + 1'b1);
         if (b_pop)
            brp_q <= PW'(brp_q + 1'b1);
         bcnt_q <= (PW+1)'(bcnt_q + {{PW{1'b0}}, b_push} - {{PW{1'b0}}, b_pop});
      end
   end

   // Buffer storage
   always_ff @(posedge SYS_CLK)
   begin
      if (b_push)
         buf_q[bwp_q] <= MEM_RDATA;
   end

   // Write mask for the word being written: partial ends merge lanes
   function automatic logic [31:0] word_mask(input logic [15:0] pos,
                                             input logic [15:0] last,
                                             input logic [31:0] fm,
                                             input logic [31:0] lm);
      logic [31:0] m;
      m = 32'hffffffff;
      if (pos == 16'h0)
         m = m & fm;
      if (pos == last)
         m = m & lm;
      word_mask = m;
   endfunction

   // A byte lane is written only where the mask covers it fully
   function automatic logic [3:0] byte_lanes(input logic [31:0] m);
      byte_lanes = {&m[31:24], &m[23:16], &m[15:8], &m[7:0]};
   endfunction

   // Memory requests: a waiting read holds the bus, else writes go first
   always_comb
   begin
      MEM_REQ    = '0;
      MEM_REQ.be = 4'hf;
      if (s_q.st == pxwa_pkg::PXWA_READ && sk_out_valid && s_q.wleft != 16'h0
          && !s_q.rdwait)
      begin
         MEM_REQ.wr    = 1'b1;
         MEM_REQ.addr  = s_q.waddr;
         MEM_REQ.wdata = sk_out_data;
         MEM_REQ.be    = byte_lanes(word_mask(s_q.wpos, s_q.wlast,
                                              s_q.fmask, s_q.lmask));
      end
      else if (s_q.st == pxwa_pkg::PXWA_READ && s_q.rleft != '0
               && s_q.inflight < (PW+1)'(DEPTH))
      begin
         MEM_REQ.rd   = 1'b1;
         MEM_REQ.addr = s_q.raddr;
      end
   end

   assign wr_fire = MEM_REQ.wr && MEM_GNT;

   // Sequencer
   always_comb
   begin
      s_d      = s_q;
      s_d.done = 1'b0;
      s_d.rdwait = MEM_REQ.rd && !MEM_GNT; // Ungranted read stays offered
      unique case (s_q.st)
         pxwa_pkg::PXWA_IDLE:
         begin
            if (START)
            begin
               s_d.st       = pxwa_pkg::PXWA_READ;
               s_d.raddr    = SRC_SIDE.base_addr;
               s_d.waddr    = DST_SIDE.base_addr;
               s_d.rleft    = 16'(SRC_SIDE.word_count + 1'b1);
               s_d.wleft    = 16'(DST_SIDE.word_count + 1'b1);
               s_d.wlast    = DST_SIDE.word_count;
               s_d.wpos     = '0;
               s_d.inflight = '0;
               s_d.fmask    = head_mask(PIXEL_FMT, DST_SIDE.start_bit_position);
               s_d.lmask    = tail_mask(PIXEL_FMT, DST_SIDE.end_bit_position);
            end
         end
         pxwa_pkg::PXWA_READ:
         begin
            if (MEM_REQ.rd && MEM_GNT)
            begin
               s_d.raddr    = 32'(s_q.raddr + 32'h4);
               s_d.rleft    = 16'(s_q.rleft - 1'b1);
               s_d.inflight = (PW+1)'(s_q.inflight + 1'b1);
            end
            if (wr_fire)
            begin
               s_d.waddr    = 32'(s_q.waddr + 32'h4);
               s_d.wleft    = 16'(s_q.wleft - 1'b1);
               s_d.wpos     = 16'(s_q.wpos + 1'b1);
               s_d.inflight = (PW+1)'(s_d.inflight - 1'b1);
               if (s_q.wleft == 16'h1)
                  s_d.st = pxwa_pkg::PXWA_DONE;
            end
         end
         pxwa_pkg::PXWA_WRITE:
            s_d.st = pxwa_pkg::PXWA_READ;
         pxwa_pkg::PXWA_DONE:
         begin
            s_d.done = 1'b1;
            s_d.st   = pxwa_pkg::PXWA_IDLE;
         end
         default:
            s_d.st = pxwa_pkg::PXWA_IDLE;
      endcase
   end

   // State register
   always_ff @(posedge SYS_CLK)
   begin
      if (SYS_RST)
      begin
         s_q    <= '0;
         s_q.st <= pxwa_pkg::PXWA_IDLE;
      end
      else
         s_q <= s_d;
   end

   assign BUSY       = (s_q.st != pxwa_pkg::PXWA_IDLE);
   assign DONE       = s_q.done;
   assign FIRST_MASK = s_q.fmask;
   assign LAST_MASK  = s_q.lmask;
endmodule
`default_nettype wire

// ===== verif/pxwa_chk_assertions.sv
// Checker on the ports of the pixel-to-word addressing block
`timescale 1ns/1ns
`default_nettype none
module pxwa_chk (
   input wire logic                 SYS_CLK,    // Clock
   input wire logic                 SYS_RST,    // Sync reset, high
   input wire logic                 START,      // Start pulse
   input wire logic [2:0]           PIXEL_FMT,  // Pixel format
   input wire pxwa_pkg::pxwa_side_t DST_SIDE,   // Destination settings
   input wire logic                 BUSY,       // Running
   input wire logic                 DONE,       // Finished pulse
   input wire logic [31:0]          FIRST_MASK, // First-word lanes
   input wire pxwa_pkg::pxwa_mreq_t MEM_REQ,    // Memory request
   input wire logic                 MEM_GNT     // Request accepted
);
   logic [31:0] wnext_q;
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (SYS_RST);
   // Expected address of the next write
   always_ff @(posedge SYS_CLK)
   begin
      if (START && !BUSY)
         wnext_q <= DST_SIDE.base_addr;
      else if (MEM_REQ.wr && MEM_GNT)
         wnext_q <= wnext_q + 32'h4;
   end
   sequence s_go; START && !BUSY; endsequence
   sequence s_end; !BUSY ##1 !DONE; endsequence
   property p_go; s_go |=> BUSY && MEM_REQ.rd; endproperty
   property p_hold; (MEM_REQ.rd || MEM_REQ.wr) && !MEM_GNT |=> $stable(MEM_REQ); endproperty
   property p_idle; MEM_REQ.rd || MEM_REQ.wr |-> BUSY; endproperty
   property p_done; DONE |-> $past(BUSY) && $past(MEM_REQ.wr && MEM_GNT, 2); endproperty
   property p_pulse; DONE |-> s_end; endproperty
   property p_first; s_go ##0 (PIXEL_FMT inside {3'h1, 3'h2, 3'h3}) ##0 DST_SIDE.word_count != 16'h0
      |=> FIRST_MASK == 32'hffffffff << $past(DST_SIDE.start_bit_position); endproperty
   property p_wbe; MEM_REQ.wr |-> MEM_REQ.be != 4'h0; endproperty
   property p_wseq; MEM_REQ.wr |-> MEM_REQ.addr == wnext_q; endproperty
   a_go:
      assert property (p_go) else $error("no read after start");
   a_hold:
      assert property (p_hold) else $error("request dropped before grant");
   a_idle:
      assert property (p_idle) else $error("request while idle");
   a_done:
      assert property (p_done) else $error("done without write grant");
   a_pulse:
      assert property (p_pulse) else $error("done or busy shape wrong");
   a_first:
      assert property (p_first) else $error("first mask wrong");
   a_wbe:
      assert property (p_wbe) else $error("write with no lanes");
   a_wseq:
      assert property (p_wseq) else $error("write address out of order");
endmodule
bind pxwa_top pxwa_chk pxwa_chk_inst (.SYS_CLK, .SYS_RST, .START, .PIXEL_FMT, .DST_SIDE,
   .BUSY, .DONE, .FIRST_MASK, .MEM_REQ, .MEM_GNT);
`default_nettype wire

// ===== verif/pxwa_mem.sv
// System memory model on the far side of the block
`timescale 1ns/1ns
`default_nettype none
module pxwa_mem (
   input  wire logic                 clk,    // Clock
   input  wire logic                 rst,    // Sync reset, high
   input  wire logic                 slow,   // Grant every other cycle
   input  wire pxwa_pkg::pxwa_mreq_t req,    // Request
   output logic                      gnt,    // Accept
   output logic                      rvalid, // Read return
   output logic [31:0]               rdata   // Read data
);
   logic tog_q;
   // Any address answers; slow mode stalls grants
   assign gnt = (req.rd | req.wr) & (~slow | tog_q);
   // Data follows the grant; idle data is scrambled
   always_ff @(posedge clk)
   begin
      tog_q  <= rst ? 1'b0 : ~tog_q;
      rvalid <= ~rst & req.rd & gnt;
      rdata  <= (req.rd & gnt) ? {req.addr[15:0], ~req.addr[15:0]} : ~rdata;
   end
endmodule
`default_nettype wire

// ===== verif/pxwa_top_tb.sv
// Testbench for the pixel-to-word addressing block
`timescale 1ns/1ns
`default_nettype none
module pxwa_top_tb;
   logic clk = 1'b0, rst = 1'b1, start = 1'b0, slow = 1'b0, busy, done, gnt, rvalid;
   logic [2:0] fmt = 3'h1;
   pxwa_pkg::pxwa_side_t src = '0, dst = '0;
   logic [31:0] fmask, lmask, rdata;
   pxwa_pkg::pxwa_mreq_t req;
   int errors = 0, compares = 0, cyc = 0, outs = 0, omax = 0;
   logic [31:0] wa[$], wd[$];
   logic [3:0] wb[$];
   always #5 clk = ~clk;
   pxwa_top pxwa_top_inst (.SYS_CLK(clk), .SYS_RST(rst), .START(start), .PIXEL_FMT(fmt),
      .SRC_SIDE(src), .DST_SIDE(dst), .BUSY(busy), .DONE(done), .FIRST_MASK(fmask),
      .LAST_MASK(lmask), .MEM_REQ(req), .MEM_GNT(gnt), .MEM_RVALID(rvalid), .MEM_RDATA(rdata));
   pxwa_mem pxwa_mem_inst (.clk(clk), .rst(rst), .slow(slow), .req(req), .gnt(gnt),
      .rvalid(rvalid), .rdata(rdata));
   // Record granted writes and words in flight
   always @(negedge clk)
   begin
      if (req.wr && gnt)
      begin
         wa.push_back(req.addr);
         wd.push_back(req.wdata);
         wb.push_back(req.be);
      end
      outs = outs + int'(req.rd && gnt) - int'(req.wr && gnt);
      omax = (outs > omax) ? outs : omax;
   end
   // Cut a hang short
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         errors++;
         wrap_up();
      end
   end
   task automatic check(input logic [31:0] seen, exp);
      compares++;
      if (seen !== exp)
      begin
         errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wrap_up();
      $display("errors=%0d compares=%0d", errors, compares);
      if (errors == 0 && compares > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // One copy with a second start while busy, then judge writes and masks
   task automatic copy(input logic [2:0] f, input logic [31:0] sa, da, input logic [15:0] n,
         input logic [4:0] sb, eb, input logic s, input logic [31:0] fm, lm);
      int i;
      logic [31:0] m;
      @(posedge clk);
      fmt <= f;
      slow <= s;
      start <= 1'b1;
      src <= '{sa, n, sb, eb};
      dst <= '{da, n, sb, eb};
      wa.delete();
      wd.delete();
      wb.delete();
      omax = 0;
      @(posedge clk) start <= 1'b0;
      @(posedge clk) start <= 1'b1;
      @(posedge clk) start <= 1'b0;
      i = 0;
      while (done !== 1'b1 && i < 3000)
      begin
         @(negedge clk);
         i++;
      end
      check({31'h0, done}, 32'h1);
      check(fmask, fm);
      check(lmask, lm);
      repeat (4) @(negedge clk);
      check({31'h0, busy}, 32'h0);
      check(32'(wa.size()), 32'(n) + 32'h1);
      for (i = 0; i < wa.size(); i++)
      begin
         check(wa[i], da + 32'(4 * i));
         check(wd[i], {sa[15:0] + 16'(4 * i), ~(sa[15:0] + 16'(4 * i))});
         m = '1;
         if (i == 0)
            m = m & fm;
         if (i == int'(n))
            m = m & lm;
         check(32'(wb[i]), 32'({&m[31:24], &m[23:16], &m[15:8], &m[7:0]}));
      end
      check(32'(omax > 32), 32'h0);
   endtask
   // Main sequence: one copy per pixel format, then a long stalled copy
   initial
   begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      copy(3'h1, 32'h1000, 32'h8000_0000, 16'h1, 5'h10, 5'h08, 1'b0, 32'hffff0000, 32'h0000ffff);
      copy(3'h2, 32'hfff0_0000, 32'h2000, 16'h3, 5'h00, 5'h10, 1'b1, '1, '1);
      copy(3'h3, 32'h3000, 32'h4000, 16'h5, 5'h18, 5'h10, 1'b0, 32'hff000000, 32'h000000ff);
      copy(3'h4, 32'h5000, 32'h6000, 16'h2, 5'h00, 5'h00, 1'b1, 32'h00ffffff, 32'h00ffffff);
      copy(3'h0, 32'h7000, 32'h7100, 16'h0, 5'h04, 5'h18, 1'b0, '1, '1);
      copy(3'h1, 32'h9000, 32'ha000, 16'h27, 5'h00, 5'h18, 1'b1, '1, '1);
      wrap_up();
   end
endmodule
`default_nettype wire
